// [rtl/brsup_regs.vh]
// Purpose: Constants for the board reset supervisor
// Assumes: mclk at 10 MHz
// Notes: How it works list below
// How it works
// R1 - Any low rail holds system reset
// R2 - Rail comparators combine as wired-OR
// R3 - Low config rails hold config FPGA, PROM
// R4 - Array FPGAs reset until config done
// R5 - Hard button asserts active-low hard reset
// R6 - Hard reset clears array FPGA configuration
// R7 - Hard reset also resets microcontroller
// R8 - Soft button pulses user logic reset
// R9 - Any FPGA configured pulses user reset
// R10 - Receivers synchronise user reset themselves
// R11 - Over 85C clears array FPGAs
// R12 - Reset when supply 5% low
// R13 - Stay reset until supply recovers
// R14 - Monitor all five primary rails
// R15 - Poll sixteen temperature monitors each second
// R16 - Hold resets 15 us after cause clears
// R17 - Reset lines are active low
`ifndef BRSUP_REGS_VH
`define BRSUP_REGS_VH
`define BRSUP_NUM_RAILS 5
`define BRSUP_NUM_FPGAS 16
`define BRSUP_CLK_HZ 10000000
`define BRSUP_HOLD_NS 15000
`define BRSUP_HOLD_CYC ((`BRSUP_HOLD_NS * (`BRSUP_CLK_HZ / 1000000) + 999) / 1000)
`define BRSUP_POLL_MS 1000
`define BRSUP_POLL_CYC (`BRSUP_POLL_MS * (`BRSUP_CLK_HZ / 1000))
`define BRSUP_CNT_W 24
`endif

// [rtl/brsup_top.v]
// Purpose: Board reset supervisor, all reset outputs registered
// Assumes: Inputs synchronous to mclk; comparators high when rail good
// Notes: Each reset output stretched by a hold counter
`timescale 1ns/100ps
`default_nettype none
`include "brsup_regs.vh"
module brsup_top #(
	parameter POLL_CYC = `BRSUP_POLL_CYC
) (
	input wire mclk,
	input wire rst,
	input wire [4:0] rail_ok,
	input wire [4:0] cfg_rail_mask,
	input wire hard_reset_button,
	input wire soft_reset_button,
	input wire cfg_fpga_done,
	input wire [15:0] fpga_done,
	input wire [15:0] over_temp,
	output reg system_reset_n,
	output reg cfg_init_n,
	output reg array_init_n,
	output reg system_hard_reset_n,
	output reg mcu_reset_n,
	output reg user_logic_reset_n,
	output reg temp_poll
);
	localparam [`BRSUP_CNT_W-1:0] HOLD = `BRSUP_HOLD_CYC;
	localparam [`BRSUP_CNT_W-1:0] CNT_ZERO = {`BRSUP_CNT_W{1'b0}};
	localparam [`BRSUP_CNT_W-1:0] POLL_LAST = POLL_CYC[`BRSUP_CNT_W-1:0] - 1'b1;
	localparam integer C_SYS = 0;
	localparam integer C_CFG = 1;
	localparam integer C_ARR = 2;
	localparam integer C_HARD = 3;
	localparam integer C_MCU = 4;
	localparam integer C_USER = 5;
	localparam integer N_CAUSE = 6;

	reg [`BRSUP_CNT_W-1:0] cnt_reg [0:5];
	reg [15:0] done_reg;
	reg [`BRSUP_CNT_W-1:0] poll_reg;
	reg [`BRSUP_CNT_W-1:0] poll_next;
	reg temp_poll_next;
	reg [5:0] cause;
	reg [5:0] release_next;
	wire rail_low;
	wire cfg_low;
	wire any_done;
	wire hot;

	// Shared fail line high when any comparator low
	function rail_fail;
		input [4:0] ok;
		begin
			rail_fail = ~&ok;
		end
	endfunction

	// Hard button or low rail
	function hard_cause;
		input low;
		input button_n;
		begin
			hard_cause = low | ~button_n;
		end
	endfunction

	// Hold counter has run out
	function hold_clear;
		input [`BRSUP_CNT_W-1:0] cnt;
		begin
			hold_clear = (cnt == CNT_ZERO);
		end
	endfunction

	// Wired-OR of comparator outputs
	assign rail_low = rail_fail(rail_ok); // R2 R12 R14
	assign cfg_low = |(~rail_ok & cfg_rail_mask); // R3
	assign any_done = |(fpga_done & ~done_reg); // R9
	assign hot = |over_temp; // R11

	// Reset causes per output
	always @* begin
		cause[C_SYS] = rail_low; // R1 R13
		cause[C_CFG] = cfg_low; // R3
		cause[C_ARR] = hard_cause(rail_low, hard_reset_button) | ~cfg_fpga_done | hot; // R4 R6 R11
		cause[C_HARD] = hard_cause(rail_low, hard_reset_button); // R5
		cause[C_MCU] = hard_cause(rail_low, hard_reset_button); // R7
		cause[C_USER] = ~soft_reset_button | any_done; // R8 R9
	end

	// Hold counters, reloaded while cause stands
	genvar i;
	generate
		for (i = 0; i < N_CAUSE; i = i + 1) begin : g_hold
			always @(posedge mclk) begin
				if (rst) begin
					cnt_reg[i] <= HOLD;
				end else if (cause[i]) begin
					cnt_reg[i] <= HOLD; // R16
				end else if (!hold_clear(cnt_reg[i])) begin
					cnt_reg[i] <= cnt_reg[i] - 1'b1;
				end
			end
		end
	endgenerate

	// Release only when cause gone and count empty
	always @* begin
		release_next = 6'h00;
		release_next[C_SYS] = ~cause[C_SYS] & hold_clear(cnt_reg[C_SYS]); // R1 R13
		release_next[C_CFG] = ~cause[C_CFG] & hold_clear(cnt_reg[C_CFG]); // R3
		release_next[C_ARR] = ~cause[C_ARR] & hold_clear(cnt_reg[C_ARR]); // R4 R6 R11
		release_next[C_HARD] = ~cause[C_HARD] & hold_clear(cnt_reg[C_HARD]); // R5
		release_next[C_MCU] = ~cause[C_MCU] & hold_clear(cnt_reg[C_MCU]); // R7
		release_next[C_USER] = ~cause[C_USER] & hold_clear(cnt_reg[C_USER]); // R8 R9
	end

	// Previous configuration flags for edge detection
	always @(posedge mclk) begin
		if (rst) begin
			done_reg <= 16'h0000;
		end else begin
			done_reg <= fpga_done; // R9
		end
	end

	// Temperature poll tick
	always @* begin
		if (poll_reg == POLL_LAST) begin
			poll_next = CNT_ZERO;
			temp_poll_next = 1'b1; // R15
		end else begin
			poll_next = poll_reg + 1'b1;
			temp_poll_next = 1'b0;
		end
	end

	always @(posedge mclk) begin
		if (rst) begin
			poll_reg <= CNT_ZERO;
			temp_poll <= 1'b0;
		end else begin
			poll_reg <= poll_next;
			temp_poll <= temp_poll_next; // R15
		end
	end

	// Board system reset
	always @(posedge mclk) begin
		if (rst) begin
			system_reset_n <= 1'b0;
		end else begin
			system_reset_n <= release_next[C_SYS]; // R1 R17
		end
	end

	// Config FPGA and PROM initialise
	always @(posedge mclk) begin
		if (rst) begin
			cfg_init_n <= 1'b0;
		end else begin
			cfg_init_n <= release_next[C_CFG]; // R3
		end
	end

	// Array FPGA initialise, clears configuration
	always @(posedge mclk) begin
		if (rst) begin
			array_init_n <= 1'b0;
		end else begin
			array_init_n <= release_next[C_ARR]; // R4 R6 R11
		end
	end

	// System hard reset
	always @(posedge mclk) begin
		if (rst) begin
			system_hard_reset_n <= 1'b0;
		end else begin
			system_hard_reset_n <= release_next[C_HARD]; // R5 R17
		end
	end

	// Microcontroller reset
	always @(posedge mclk) begin
		if (rst) begin
			mcu_reset_n <= 1'b0;
		end else begin
			mcu_reset_n <= release_next[C_MCU]; // R7
		end
	end

	// User logic reset, configuration kept
	always @(posedge mclk) begin
		if (rst) begin
			user_logic_reset_n <= 1'b0;
		end else begin
			user_logic_reset_n <= release_next[C_USER]; // R8 R17
		end
	end
endmodule // brsup_top
`default_nettype wire

// [sim/brsup_fpga.sv]
`timescale 1ns/100ps
`default_nettype none
module brsup_fpga (input wire logic mclk, array_init_n, user_logic_reset_n, output logic [15:0] fpga_done);
	logic [1:0] sync_reg;
	always @(posedge mclk) fpga_done <= array_init_n ? {fpga_done[14:0], 1'h1} : 16'h0;
	always @(posedge mclk) sync_reg <= {sync_reg[0], user_logic_reset_n};
endmodule // brsup_fpga

// [sim/brsup_chk_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module brsup_chk (input wire logic mclk, rst, hard_reset_button, soft_reset_button, cfg_fpga_done, system_reset_n,
	array_init_n, system_hard_reset_n, mcu_reset_n, user_logic_reset_n, cfg_init_n, temp_poll,
	input wire logic [4:0] rail_ok, cfg_rail_mask, input wire logic [15:0] over_temp, fpga_done);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (rst);
	wire lo = rail_ok != 5'h1f, hc = lo || !hard_reset_button;
	rail_low_a: assert property (lo |=> !system_reset_n) else $error("r");
	rail_hold_a: assert property ($rose(system_reset_n) |-> $past(lo || rst, 152)) else $error("h");
	cfg_rail_a: assert property (|(~rail_ok & cfg_rail_mask) |=> !cfg_init_n) else $error("i");
	done_pulse_a: assert property (|(fpga_done & ~$past(fpga_done)) |=> !user_logic_reset_n) else $error("d");
	poll_gap_a: assert property (temp_poll |=> !temp_poll) else $error("p");
	cfg_wait_a: assert property (!cfg_fpga_done |=> !array_init_n) else $error("w");
	hard_btn_a: assert property (!hard_reset_button |=> !system_hard_reset_n) else $error("b");
	hard_clear_a: assert property (hc |=> !array_init_n && !mcu_reset_n) else $error("c");
	soft_btn_a: assert property (!soft_reset_button |=> !user_logic_reset_n) else $error("s");
	temp_trip_a: assert property (|over_temp |=> !array_init_n) else $error("t");
	mcu_hold_a: assert property ($rose(mcu_reset_n) |-> $past(hc || rst, 152)) else $error("m");
endmodule // brsup_chk
bind brsup_top brsup_chk chk (.*);

// [sim/tb_board_reset_supervisor.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_board_reset_supervisor;
	logic mclk = 0, rst = 1, hard_reset_button = 1, soft_reset_button = 1, cfg_fpga_done = 1;
	logic [4:0] rail_ok = 5'h1f, cfg_rail_mask = 5'h0; logic [15:0] over_temp = 16'h0, pv; logic [5:0] c, e;
	wire [15:0] fpga_done; wire system_reset_n, cfg_init_n, array_init_n, system_hard_reset_n, mcu_reset_n, user_logic_reset_n;
	wire temp_poll; logic ep; int pc = 0;
	wire [5:0] o = {system_reset_n, cfg_init_n, array_init_n, system_hard_reset_n, mcu_reset_n, user_logic_reset_n};
	int fails = 0, n_compared = 0, cnt[6];
	brsup_top #(.POLL_CYC(20)) dut (.*);
	brsup_fpga fm (.*);
	task chk(int k, logic s, x);
		n_compared++;
		if (s !== x) begin fails++; $display("[ERR] out%0d exp %b got %b", k, x, s); end
	endtask
	task results;
		if (fails == 0 && n_compared > 0) $display("== PASSED =="); else $display("== FAILED ==");
		$finish;
	endtask
	initial forever #50 mclk = ~mclk;
	initial begin #4000000 fails++; results; end
	always @(posedge mclk) begin
		c = {rail_ok != 5'h1f, |(~rail_ok & cfg_rail_mask), !(&rail_ok && cfg_fpga_done && hard_reset_button && !over_temp),
			{2{!(&rail_ok && hard_reset_button)}}, !soft_reset_button || |(fpga_done & ~pv)};
		for (int i = 0; i < 6; i++) begin e[i] = !(rst || c[i] || cnt[i]); cnt[i] = rst || c[i] ? 150 : cnt[i] - !!cnt[i]; end
		pv = fpga_done;
		ep = !rst && pc == 19;
		pc = rst || pc == 19 ? 0 : pc + 1;
	end
	always @(negedge mclk) for (int i = 0; i < 6; i++) chk(i, o[i], e[i]);
	always @(negedge mclk) chk(6, temp_poll, ep);
	initial begin
		void'($urandom(32'ha8cb));
		repeat (60) begin
			repeat (16 + $urandom % 400) @(posedge mclk);
			rst <= $urandom % 12 == 0;
			rail_ok <= 5'($urandom | $urandom | $urandom);
			{hard_reset_button, soft_reset_button, cfg_fpga_done} <= 3'($urandom | $urandom);
			over_temp <= $urandom % 4 ? 16'h0 : 16'($urandom);
			cfg_rail_mask <= 5'($urandom);
		end
		results;
	end
endmodule // tb_board_reset_supervisor
